/* hdl/tm8_pkg.sv */
/*
 Shared constants for the eight-bit event, divider and modulation timer
 channel: register offsets, control field positions, reset values, modes.
 Assumes an 8-bit register port with a 2-bit word address.
*/
package tm8_pkg;

   // Register word offsets
   localparam logic [1:0] ADDR_CTRL = 2'h0;
   localparam logic [1:0] ADDR_CMP  = 2'h1;
   localparam logic [1:0] ADDR_DUTY = 2'h2;
   localparam logic [1:0] ADDR_CNT  = 2'h3;

   // Control register fields
   localparam int CTRL_FF_BIT   = 7;
   localparam int CTRL_SRC_MSB  = 6;
   localparam int CTRL_SRC_LSB  = 4;
   localparam int CTRL_RUN_BIT  = 3;
   localparam int CTRL_MODE_MSB = 2;
   localparam int CTRL_MODE_LSB = 0;

   // Reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] CMP_RST  = 8'hFF;
   localparam logic [7:0] DUTY_RST = 8'hFF;
   localparam logic [7:0] CNT_RST  = 8'h00;

   // Counter limits
   localparam logic [7:0] CNT_ONE = 8'h01;
   localparam logic [7:0] CNT_MAX = 8'hFF;

   // Source selects and the documented setup values
   localparam logic [2:0] SRC_FC_DIV128  = 3'h1;
   localparam logic [7:0] CTRL_DIV_SETUP = 8'h11;
   localparam logic [7:0] CTRL_DIV_START = 8'h19;

   // Operating modes
   typedef enum logic [2:0] {
      TM8_MODE_EVENT = 3'h0,
      TM8_MODE_DIV   = 3'h1,
      TM8_MODE_PWM   = 3'h2
   } tm8_mode_t;

endpackage : tm8_pkg

/* hdl/tm8_fall_detect.sv */
/*
 Falling-edge detector for the external count input.
 Assumes the pin is already synchronous to clk and that each level
 lasts at least two cycles, so no glitch filter is needed.
*/
`timescale 1ns/100ps
module tm8_fall_detect (
   // Clock, reset, enable
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic ce,
   // Pin and event
   input  wire logic pin,
   output logic      fall
);

   logic pin_q;
   logic fall_q;

   // Idle level taken as high, so a pin already low at release counts one edge
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_q <= 1'b1;
      end else if (ce) begin
         pin_q <= pin;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         fall_q <= 1'b0;
      end else if (ce) begin
         fall_q <= pin_q & ~pin;
      end
   end

   assign fall = fall_q;

endmodule : tm8_fall_detect

/* hdl/tm8_timer_channel.sv */
/*
 Eight-bit timer channel with event counter, divider output and
 modulation output modes, one channel interrupt pulse and inverted pins.
 Assumes an external prescaler that supplies one-cycle tick enables,
 one per source select code, and a synchronous count input pin.
*/
`timescale 1ns/100ps
module tm8_timer_channel #(
   parameter int NUM_SRC = 8
) (
   // Clock, reset, enable
   input  wire logic               clk,
   input  wire logic               arst_n,
   input  wire logic               ce,
   // Register port
   input  wire logic [1:0]         reg_addr,
   input  wire logic [7:0]         reg_wdata,
   input  wire logic               reg_wr,
   input  wire logic               reg_rd,
   output logic      [7:0]         reg_rdata,
   // Prescaled source ticks
   input  wire logic [NUM_SRC-1:0] src_tick,
   // Pins
   input  wire logic               count_input_pin,
   output logic                    divider_out_n,
   output logic                    modulation_out_n,
   output logic                    pulse_gen_out_n,
   // Interrupt request
   output logic                    channel_irq
);

   logic [7:0]        channel_control_reg;
   logic [7:0]        compare_value_reg;
   logic [7:0]        duty_buf_q;
   logic [7:0]        duty_act_q;
   logic [7:0]        cnt_q;
   logic              ff_q;
   logic              irq_q;
   logic [7:0]        rdata_q;
   logic              fall_edge;
   logic              run_q;
   logic              flipflop_init_bit;
   logic [2:0]        src_sel;
   tm8_pkg::tm8_mode_t mode;
   logic              mode_ok;
   logic              tick;
   logic [7:0]        cnt_inc;
   logic              cmp_match;
   logic              pwm_ovf;
   logic              pwm_match;
   logic              toggle_hit;
   logic              event_hit;
   logic              wr_ctrl;
   logic              wr_cmp;
   logic              wr_duty;

   // Count input edge
   tm8_fall_detect u_fall (
      .clk    (clk),
      .arst_n (arst_n),
      .ce     (ce),
      .pin    (count_input_pin),
      .fall   (fall_edge)
   );

   // Field decode
   assign run_q             = channel_control_reg[tm8_pkg::CTRL_RUN_BIT];
   assign flipflop_init_bit = channel_control_reg[tm8_pkg::CTRL_FF_BIT];
   assign src_sel           = channel_control_reg[tm8_pkg::CTRL_SRC_MSB:tm8_pkg::CTRL_SRC_LSB];
   assign mode = tm8_pkg::tm8_mode_t'(
      channel_control_reg[tm8_pkg::CTRL_MODE_MSB:tm8_pkg::CTRL_MODE_LSB]);

   // Unused mode codes leave the counter idle rather than guess a behaviour
   always_comb begin
      case (mode)
         tm8_pkg::TM8_MODE_EVENT: mode_ok = 1'b1;
         tm8_pkg::TM8_MODE_DIV:   mode_ok = 1'b1;
         tm8_pkg::TM8_MODE_PWM:   mode_ok = 1'b1;
         default:                 mode_ok = 1'b0;
      endcase
   end

   // Count enable
   always_comb begin
      if (!run_q || !mode_ok) begin
         tick = 1'b0;
      end else if (mode == tm8_pkg::TM8_MODE_EVENT) begin
         tick = fall_edge;
      end else begin
         tick = src_tick[src_sel];
      end
   end

   // Comparisons
   assign cnt_inc   = cnt_q + tm8_pkg::CNT_ONE;
   assign cmp_match = (cnt_inc == compare_value_reg);
   assign pwm_ovf   = (cnt_q == tm8_pkg::CNT_MAX);
   assign pwm_match = (cnt_inc == duty_act_q) && !pwm_ovf;

   always_comb begin
      case (mode)
         tm8_pkg::TM8_MODE_EVENT: begin
            toggle_hit = 1'b0;
            event_hit  = cmp_match;
         end
         tm8_pkg::TM8_MODE_DIV: begin
            toggle_hit = cmp_match;
            event_hit  = cmp_match;
         end
         tm8_pkg::TM8_MODE_PWM: begin
            toggle_hit = pwm_ovf || pwm_match;
            event_hit  = pwm_ovf;
         end
         default: begin
            toggle_hit = 1'b0;
            event_hit  = 1'b0;
         end
      endcase
   end

   // Register strobes
   assign wr_ctrl = reg_wr && (reg_addr == tm8_pkg::ADDR_CTRL);
   assign wr_cmp  = reg_wr && (reg_addr == tm8_pkg::ADDR_CMP);
   assign wr_duty = reg_wr && (reg_addr == tm8_pkg::ADDR_DUTY);

   // Control register
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         channel_control_reg <= tm8_pkg::CTRL_RST;
      end else if (ce && wr_ctrl) begin
         channel_control_reg <= reg_wdata;
      end
   end

   // Compare register, no buffer stage
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         compare_value_reg <= tm8_pkg::CMP_RST;
      end else if (ce && wr_cmp) begin
         compare_value_reg <= reg_wdata;
      end
   end

   // Duty buffer stage
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         duty_buf_q <= tm8_pkg::DUTY_RST;
      end else if (ce && wr_duty) begin
         duty_buf_q <= reg_wdata;
      end
   end

   // Active duty; a write in the transfer cycle lands in the buffer only
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         duty_act_q <= tm8_pkg::DUTY_RST;
      end else if (ce) begin
         if (tick && pwm_ovf && mode == tm8_pkg::TM8_MODE_PWM) begin
            duty_act_q <= duty_buf_q;
         end else if (wr_duty && (!run_q || mode != tm8_pkg::TM8_MODE_PWM)) begin
            duty_act_q <= reg_wdata;
         end
      end
   end

   // Up-counter, held at zero while stopped
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q <= tm8_pkg::CNT_RST;
      end else if (ce) begin
         if (!run_q) begin
            cnt_q <= tm8_pkg::CNT_RST;
         end else if (tick) begin
            if (mode == tm8_pkg::TM8_MODE_PWM) begin
               if (pwm_ovf) begin
                  cnt_q <= tm8_pkg::CNT_RST;
               end else begin
                  cnt_q <= cnt_inc;
               end
            end else if (cmp_match) begin
               cnt_q <= tm8_pkg::CNT_RST;
            end else begin
               cnt_q <= cnt_inc;
            end
         end
      end
   end

   // Output flip-flop; preset only from a stopped state so a stopping write holds it
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ff_q <= 1'b0;
      end else if (ce) begin
         if (wr_ctrl && !run_q) begin
            ff_q <= reg_wdata[tm8_pkg::CTRL_FF_BIT];
         end else if (tick && toggle_hit) begin
            ff_q <= ~ff_q;
         end
      end
   end

   // Interrupt pulse
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_q <= 1'b0;
      end else if (ce) begin
         irq_q <= tick && event_hit;
      end else begin
         irq_q <= 1'b0;
      end
   end

   // Read port; duty reads show the active value
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_q <= 8'h00;
      end else if (ce) begin
         if (reg_rd) begin
            case (reg_addr)
               tm8_pkg::ADDR_CTRL: rdata_q <= channel_control_reg;
               tm8_pkg::ADDR_CMP:  rdata_q <= compare_value_reg;
               tm8_pkg::ADDR_DUTY: rdata_q <= duty_act_q;
               tm8_pkg::ADDR_CNT:  rdata_q <= cnt_q;
               default:            rdata_q <= 8'h00;
            endcase
         end else begin
            rdata_q <= 8'h00;
         end
      end
   end

   // Pins share one flip-flop, hence stray pulses if the init bit is misused
   assign divider_out_n    = ~ff_q;
   assign modulation_out_n = ~ff_q;
   assign pulse_gen_out_n  = ~ff_q;
   assign channel_irq      = irq_q;
   assign reg_rdata        = rdata_q;

   // Checks
   sequence s_event_tick;
      ce && run_q && mode == tm8_pkg::TM8_MODE_EVENT && fall_edge;
   endsequence

   sequence s_div_tick;
      ce && run_q && mode == tm8_pkg::TM8_MODE_DIV && src_tick[src_sel];
   endsequence

   sequence s_pwm_tick;
      ce && run_q && mode == tm8_pkg::TM8_MODE_PWM && src_tick[src_sel];
   endsequence

   a_event_advance: assert property (@(posedge clk) disable iff (!arst_n)
      s_event_tick ##0 !cmp_match |=> cnt_q == $past(cnt_inc))
      else $error("event count did not advance");

   a_event_match: assert property (@(posedge clk) disable iff (!arst_n)
      s_event_tick ##0 cmp_match |=> cnt_q == tm8_pkg::CNT_RST && channel_irq)
      else $error("event match did not clear and interrupt");

   a_cmp_direct: assert property (@(posedge clk) disable iff (!arst_n)
      ce && wr_cmp |=> compare_value_reg == $past(reg_wdata))
      else $error("compare write not immediate");

   a_div_toggle: assert property (@(posedge clk) disable iff (!arst_n)
      s_div_tick ##0 cmp_match |=> ff_q != $past(ff_q) && channel_irq
      && cnt_q == tm8_pkg::CNT_RST)
      else $error("divider match did not toggle");

   a_div_hold: assert property (@(posedge clk) disable iff (!arst_n)
      s_div_tick ##0 !cmp_match ##0 !wr_ctrl |=> $stable(ff_q) && !channel_irq)
      else $error("divider toggled without match");

   a_preset_stop: assert property (@(posedge clk) disable iff (!arst_n)
      ce && wr_ctrl && !run_q && !reg_wdata[tm8_pkg::CTRL_FF_BIT]
      && !reg_wdata[tm8_pkg::CTRL_RUN_BIT]
      |=> divider_out_n ##1 (divider_out_n || $past(ce && wr_ctrl)))
      else $error("stopped preset did not drive pin high");

   a_stop_holds: assert property (@(posedge clk) disable iff (!arst_n)
      !run_q && !(ce && wr_ctrl) |=> $stable(ff_q))
      else $error("output moved while stopped");

   a_stop_write: assert property (@(posedge clk) disable iff (!arst_n)
      ce && wr_ctrl && run_q && !reg_wdata[tm8_pkg::CTRL_RUN_BIT] && !(tick && toggle_hit)
      |=> $stable(modulation_out_n))
      else $error("stopping write changed the pin");

   a_pwm_match: assert property (@(posedge clk) disable iff (!arst_n)
      s_pwm_tick ##0 pwm_match |=> ff_q != $past(ff_q)
      && cnt_q == $past(cnt_inc) && !channel_irq)
      else $error("modulation match wrong");

   a_pwm_overflow: assert property (@(posedge clk) disable iff (!arst_n)
      s_pwm_tick ##0 pwm_ovf |=> ff_q != $past(ff_q)
      && cnt_q == tm8_pkg::CNT_RST && channel_irq)
      else $error("modulation overflow wrong");

   a_duty_transfer: assert property (@(posedge clk) disable iff (!arst_n)
      s_pwm_tick ##0 pwm_ovf |=> duty_act_q == $past(duty_buf_q))
      else $error("duty not transferred on overflow");

   a_duty_buffered: assert property (@(posedge clk) disable iff (!arst_n)
      ce && wr_duty && run_q && mode == tm8_pkg::TM8_MODE_PWM && !(tick && pwm_ovf)
      |=> $stable(duty_act_q) && duty_buf_q == $past(reg_wdata))
      else $error("running duty write bypassed buffer");

   a_duty_read: assert property (@(posedge clk) disable iff (!arst_n)
      ce && reg_rd && reg_addr == tm8_pkg::ADDR_DUTY |=> reg_rdata == $past(duty_act_q))
      else $error("duty read not active value");

   a_tick_gate: assert property (@(posedge clk) disable iff (!arst_n)
      run_q && !(ce && tick) |=> $stable(cnt_q))
      else $error("counter moved without tick");

   a_irq_pulse: assert property (@(posedge clk) disable iff (!arst_n)
      channel_irq |-> $past(ce) && $past(tick) && $past(event_hit))
      else $error("interrupt without event");

   // Restart from zero with a single pulse keeps the period at the full span
   a_pwm_period: assert property (@(posedge clk) disable iff (!arst_n)
      s_pwm_tick ##0 pwm_ovf |=> cnt_q == tm8_pkg::CNT_RST && channel_irq
      ##1 !channel_irq)
      else $error("modulation period wrong");

endmodule : tm8_timer_channel

/* tb/tm8_pulse_src.sv */
/*
 Far-side model of the count input: sends bursts of falling-edge pulses.
 Assumes a pulled-up input line, idle high between bursts.
*/
`timescale 1ns/100ps
module tm8_pulse_src (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       arst_n,
   // Burst request
   input  wire logic       start,
   input  wire logic [7:0] num,
   // Pin side
   output logic            pin,
   output logic            busy
);
   // Margin over the two-cycle minimum level time
   localparam logic [7:0] HALF = 8'h03;
   logic [7:0] left_q;
   logic [7:0] ph_q;

   assign busy = (left_q != 8'h00);
   assign pin  = !(busy && ph_q < HALF);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         left_q <= 8'h00;
         ph_q   <= 8'h00;
      end else if (start) begin
         left_q <= num;
         ph_q   <= 8'h00;
      end else if (busy) begin
         if (ph_q == 2 * HALF - 1) begin
            ph_q   <= 8'h00;
            left_q <= left_q - 8'h01;
         end else begin
            ph_q <= ph_q + 8'h01;
         end
      end
   end
endmodule : tm8_pulse_src

/* tb/tm8_tb.sv */
/*
 Self-checking bench for the timer channel in event, divider, modulation.
 Assumes source 1 ticks every fourth clock, source 0 each clock; ce drops low only in the freeze test.
*/
`timescale 1ns/100ps
module tb;
   logic       clk;
   logic       arst_n;
   logic       ce;
   logic [1:0] reg_addr;
   logic [7:0] reg_wdata;
   logic       reg_wr;
   logic       reg_rd;
   logic [7:0] reg_rdata;
   logic [7:0] src_tick;
   logic [1:0] tg_q;
   logic       count_input_pin;
   logic       divider_out_n;
   logic       modulation_out_n;
   logic       pulse_gen_out_n;
   logic       channel_irq;
   logic       ps_start;
   logic [7:0] ps_num;
   logic       ps_busy;
   int         errors;
   int         tests_run;

   tm8_timer_channel #(.NUM_SRC(8)) dut (.clk(clk), .arst_n(arst_n), .ce(ce),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .src_tick(src_tick), .count_input_pin(count_input_pin),
      .divider_out_n(divider_out_n), .modulation_out_n(modulation_out_n),
      .pulse_gen_out_n(pulse_gen_out_n), .channel_irq(channel_irq));

   tm8_pulse_src src (.clk(clk), .arst_n(arst_n), .start(ps_start), .num(ps_num),
      .pin(count_input_pin), .busy(ps_busy));

   // Sources 0 and 1 tick at different rates, so a wrong select shows in the period
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tg_q     <= 2'h0;
         src_tick <= 8'h00;
      end else begin
         tg_q     <= tg_q + 2'h1;
         src_tick <= {6'h00, tg_q == 2'h3, 1'b1};
      end
   end

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic wrap_up;
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic chk_n(input int got, input int exp);
      tests_run++;
      if (got != exp) begin
         errors++;
         $display("ERROR t=%0t cycles got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_n

   function automatic logic [7:0] pins();
      return {5'h00, divider_out_n, modulation_out_n, pulse_gen_out_n};
   endfunction : pins

   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
   endtask : wr

   task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask : rd_chk

   // Counts edges until irq (sel 0) or modulation pin (sel 1) reaches lvl
   task automatic wait_ev(input bit sel, input logic lvl, input int lim, output int n);
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while ((sel ? modulation_out_n : channel_irq) !== lvl && n < lim);
      if ((sel ? modulation_out_n : channel_irq) !== lvl) begin
         errors++;
         $display("ERROR t=%0t wait got=%h exp=%h", $time, !lvl, lvl);
         wrap_up();
      end
   endtask : wait_ev

   task automatic pulse(input logic [7:0] k, input bit hold);
      int i;
      @(posedge clk);
      ps_start <= 1'b1;
      ps_num   <= k;
      @(posedge clk);
      ps_start <= 1'b0;
      i = 0;
      // Edge detection lags the pin by one cycle, the count by two
      while (hold && (ps_busy || i < 4) && i < 200) begin
         @(posedge clk);
         i++;
      end
      #1;
   endtask : pulse

   task automatic t_reset;
      rd_chk(tm8_pkg::ADDR_CTRL, tm8_pkg::CTRL_RST);
      rd_chk(tm8_pkg::ADDR_CMP, tm8_pkg::CMP_RST);
      rd_chk(tm8_pkg::ADDR_DUTY, tm8_pkg::DUTY_RST);
      chk(pins(), 8'h07);
      wr(tm8_pkg::ADDR_CNT, 8'h55);
      rd_chk(tm8_pkg::ADDR_CNT, 8'h00);
   endtask : t_reset

   task automatic t_divider;
      int n;
      logic p;
      wr(tm8_pkg::ADDR_CMP, 8'h04);
      wr(tm8_pkg::ADDR_CTRL, tm8_pkg::CTRL_DIV_SETUP);
      rd_chk(tm8_pkg::ADDR_CNT, 8'h00);
      wr(tm8_pkg::ADDR_CTRL, tm8_pkg::CTRL_DIV_START);
      wait_ev(0, 1'b1, 100, n);
      for (int i = 0; i < 2; i++) begin
         p = divider_out_n;
         wait_ev(0, 1'b0, 5, n);
         chk_n(n, 1);
         wait_ev(0, 1'b1, 100, n);
         chk_n(n, 15);
         chk({7'h00, divider_out_n}, {7'h00, !p});
      end
   endtask : t_divider

   task automatic t_stop_hold;
      logic p;
      p = divider_out_n;
      wr(tm8_pkg::ADDR_CTRL, tm8_pkg::CTRL_DIV_SETUP);
      repeat (20) @(posedge clk);
      #1;
      chk({7'h00, divider_out_n}, {7'h00, p});
      rd_chk(tm8_pkg::ADDR_CNT, 8'h00);
      wr(tm8_pkg::ADDR_CTRL, 8'h91);
      chk(pins(), 8'h00);
      wr(tm8_pkg::ADDR_CTRL, 8'h11);
      chk(pins(), 8'h07);
   endtask : t_stop_hold

   task automatic t_event;
      int n;
      wr(tm8_pkg::ADDR_CMP, 8'h03);
      wr(tm8_pkg::ADDR_CTRL, 8'h08);
      pulse(8'h01, 1'b1);
      rd_chk(tm8_pkg::ADDR_CNT, 8'h01);
      wr(tm8_pkg::ADDR_CMP, 8'h02);
      pulse(8'h01, 1'b0);
      wait_ev(0, 1'b1, 40, n);
      pulse(8'h00, 1'b1);
      rd_chk(tm8_pkg::ADDR_CNT, 8'h00);
      pulse(8'h01, 1'b1);
      rd_chk(tm8_pkg::ADDR_CNT, 8'h01);
      chk(pins(), 8'h07);
   endtask : t_event

   // Pulses sent while frozen must leave the count alone
   task automatic t_freeze;
      @(posedge clk);
      ce <= 1'b0;
      pulse(8'h01, 1'b1);
      @(posedge clk);
      ce <= 1'b1;
      rd_chk(tm8_pkg::ADDR_CNT, 8'h01);
      pulse(8'h01, 1'b1);
      rd_chk(tm8_pkg::ADDR_CNT, 8'h00);
   endtask : t_freeze

   task automatic t_pwm;
      int n;
      wr(tm8_pkg::ADDR_CTRL, 8'h02);
      wr(tm8_pkg::ADDR_DUTY, 8'h40);
      rd_chk(tm8_pkg::ADDR_DUTY, 8'h40);
      wr(tm8_pkg::ADDR_CTRL, 8'h0A);
      wait_ev(0, 1'b1, 600, n);
      wait_ev(1, 1'b0, 300, n);
      chk_n(n, 64);
      wait_ev(0, 1'b1, 300, n);
      chk_n(n, 192);
      chk({7'h00, modulation_out_n}, 8'h01);
      wr(tm8_pkg::ADDR_DUTY, 8'h80);
      rd_chk(tm8_pkg::ADDR_DUTY, 8'h40);
      wait_ev(0, 1'b1, 300, n);
      wait_ev(1, 1'b0, 300, n);
      chk_n(n, 128);
      rd_chk(tm8_pkg::ADDR_DUTY, 8'h80);
      wr(tm8_pkg::ADDR_CTRL, 8'h02);
      chk(pins(), 8'h00);
      wr(tm8_pkg::ADDR_CTRL, 8'h02);
      chk(pins(), 8'h07);
      wr(tm8_pkg::ADDR_CTRL, 8'h82);
      chk(pins(), 8'h00);
      wr(tm8_pkg::ADDR_CTRL, 8'h8A);
      wait_ev(0, 1'b1, 600, n);
      chk({7'h00, modulation_out_n}, 8'h00);
      wait_ev(1, 1'b1, 300, n);
      chk_n(n, 128);
   endtask : t_pwm

   initial begin
      arst_n    = 1'b0;
      ce        = 1'b1;
      reg_addr  = 2'h0;
      reg_wdata = 8'h00;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      ps_start  = 1'b0;
      ps_num    = 8'h00;
      errors    = 0;
      tests_run = 0;
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      t_reset();
      t_divider();
      t_stop_hold();
      t_event();
      t_freeze();
      t_pwm();
      wrap_up();
   end
endmodule : tb
